// File: rtl/pipe_hazard_regs.svh
// Offsets, field positions, reset values and codes of the hazard controller.
`ifndef PIPE_HAZARD_REGS_SVH
`define PIPE_HAZARD_REGS_SVH
// ****************************************************************
// Register byte offsets on the bus.
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_BANK_BASE   8'h08
`define OFS_STACK_PTR   8'h0c
`define OFS_STATUS_WORD 8'h10
`define OFS_PORT_VIEW   8'h14
// ****************************************************************
// Control fields and reset value.
// ****************************************************************
`define CTRL_RUN_BIT    0
`define CTRL_CLR_BIT    1
`define CTRL_RESET      32'h0000_0001
// ****************************************************************
// Core register identities written by the execute stage.
// ****************************************************************
`define ID_BANK_BASE    4'h0
`define ID_PAGE0        4'h1
`define ID_STACK_PTR    4'h5
`define ID_STATUS_WORD  4'h6
`define ID_SYS_CONFIG   4'h7
`define ID_BUS_PROPS    4'h8
`define ID_ADDR_WINDOW  4'h9
`define ID_PORT_DIR     4'ha
`define ID_PORT_LATCH   4'hb
`define ID_LAST         4'hb
// ****************************************************************
// Status word and system configuration fields.
// ****************************************************************
`define PSW_IEN_BIT     11
`define PSW_LVL_LSB     12
`define SYSCFG_ROM_BIT  10
// ****************************************************************
// Bus request lanes, highest priority first.
// ****************************************************************
`define REQ_WRITE       0
`define REQ_FETCH       1
`define REQ_READ        2
`endif

// File: rtl/pipe_hazard_pkg.sv
// Types shared by the pipeline hazard controller.
package pipe_hazard_pkg;
    typedef logic [3:0] sfr_id_t;
    // Register write made by the instruction in execute.
    typedef struct packed {
        logic        valid;
        sfr_id_t     id;
        logic [15:0] data;
    } exe_wr_s;
    // Pointer and stack usage of the instruction in decode.
    typedef struct packed {
        logic        uses_bank;
        logic        uses_page;
        logic [1:0]  page_sel;
        logic        stack_pop;
        logic        sfr_read;
        sfr_id_t     sfr_id;
        logic        tests_flags;
    } dec_use_s;
endpackage

// File: rtl/pipe_hazard_ctrl.sv
// Hazard control of a four-stage core pipeline with an AHB-Lite view.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`include "pipe_hazard_regs.svh"
module pipe_hazard_ctrl
    import pipe_hazard_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    // Pipeline stepping from the core.
    input  wire logic        ADV_I,
    input  wire logic        FETCH_VALID_I,
    input  wire logic        ABS_BRANCH_I,
    input  wire exe_wr_s     EXE_WR_I,
    input  wire logic        FLAG_WR_I,
    input  wire logic [3:0]  FLAG_VAL_I,
    input  wire dec_use_s    DEC_USE_I,
    // Interrupt request and bus requests.
    input  wire logic        IRQ_I,
    input  wire logic [3:0]  IRQ_LVL_I,
    input  wire logic [2:0]  BUS_REQ_I,
    input  wire logic [15:0] PORT_PIN_I,
    // Results towards the core.
    output logic [15:0]      DEC_PTR_O,
    output logic [15:0]      POP_SP_O,
    output logic [15:0]      PUSH_SP_O,
    output logic             IRQ_ACK_O,
    output logic [2:0]       BUS_GNT_O,
    output logic [15:0]      PORT_DIR_O,
    output logic [15:0]      PORT_RD_O,
    output logic [15:0]      SYS_CFG_O,
    output logic [31:0]      BUS_AREA_O,
    output logic             ROM_FETCH_EN_O,
    output logic             STALL_HALF_O,
    output logic             STALL_FULL_O,
    output logic             RETIRE_O,
    // AHB-Lite slave.
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP
);
    localparam int NREG = 12;              // Number of tracked registers.
    // ****************************************************************
    // Pointer decode shared by selection and hazard counting.
    // ****************************************************************
    // Returns the register a decode-stage address calculation reads.
    function automatic sfr_id_t ptr_id(input dec_use_s u);
        if (u.uses_page) begin
            ptr_id = sfr_id_t'(`ID_PAGE0 + {2'b00, u.page_sel});
        end else begin
            ptr_id = `ID_BANK_BASE;
        end
    endfunction
    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic [15:0] arch [NREG];              // Current values.
    logic [15:0] lag [NREG];               // Values one instruction old.
    logic [15:0] next_arch [NREG];
    logic [15:0] next_lag [NREG];
    logic [3:0]  stage;                    // Fetch..writeback occupancy.
    logic [3:0]  next_stage;
    logic        rom_en;                   // Mapped ROM fetch permitted.
    logic        next_rom_en;
    logic [15:0] haz_cnt;                  // Stale pointer uses seen.
    logic [15:0] next_haz_cnt;
    logic [31:0] ctrl;                     // Software control word.
    logic [31:0] next_ctrl;
    logic        adv;                      // Pipeline step this cycle.
    logic        wr_ok;                    // Execute write hits a register.
    logic        bus_wr;                   // Control word bus write in data phase.
    logic        bus_wr_q;                 // Captured address phase write.
    logic [7:0]  bus_addr_q;               // Captured address phase offset.
    logic [15:0] pin_s1;                   // Pin sync, first stage.
    logic [15:0] pin_s2;                   // Pin sync, second stage.
    logic [15:0] pin_s3;                   // Pin sync, third stage.
    logic [15:0] pin_ok;                   // Accepted pin level.
    assign adv    = ADV_I && ctrl[`CTRL_RUN_BIT];
    assign wr_ok  = EXE_WR_I.valid && (EXE_WR_I.id <= `ID_LAST);
    assign bus_wr = bus_wr_q && (bus_addr_q == `OFS_CTRL);
    // Next register values: execute writes land, lagged copies follow.
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            next_arch[i] = arch[i];
            next_lag[i]  = lag[i];
            if (adv) begin
                next_lag[i] = arch[i];
                if (wr_ok && EXE_WR_I.id == sfr_id_t'(i)) begin
                    next_arch[i] = EXE_WR_I.data;
                end
            end
        end
        // Implicit flag updates lose to an explicit status word write.
        if (adv && FLAG_WR_I &&
            !(wr_ok && EXE_WR_I.id == `ID_STATUS_WORD)) begin
            next_arch[`ID_STATUS_WORD][3:0] = FLAG_VAL_I;
        end
        next_stage  = adv ? {stage[2:0], FETCH_VALID_I} : stage;
        // ROM mapping only counts once an absolute branch executes.
        next_rom_en = (adv && ABS_BRANCH_I) ?
                      lag[`ID_SYS_CONFIG][`SYSCFG_ROM_BIT] : rom_en;
        next_haz_cnt = haz_cnt;
        if (bus_wr && HWDATA[`CTRL_CLR_BIT]) begin
            next_haz_cnt = '0;
        end
        // Count a decode pointer read that misses the execute write.
        if (adv && wr_ok && (DEC_USE_I.uses_bank || DEC_USE_I.uses_page)
            && EXE_WR_I.id == ptr_id(DEC_USE_I)) begin
            next_haz_cnt = haz_cnt + 16'h0001;
        end
        next_ctrl = bus_wr ? {30'h0, 1'b0, HWDATA[`CTRL_RUN_BIT]} : ctrl;
    end
    // Registers the state group.
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < NREG; i++) begin
                arch[i] <= 16'h0000;
                lag[i]  <= 16'h0000;
            end
            stage   <= 4'h0;
            rom_en  <= 1'b0;
            haz_cnt <= 16'h0000;
            ctrl    <= `CTRL_RESET;
        end else begin
            arch    <= next_arch;
            lag     <= next_lag;
            stage   <= next_stage;
            rom_en  <= next_rom_en;
            haz_cnt <= next_haz_cnt;
            ctrl    <= next_ctrl;
        end
    end
    // ****************************************************************
    // Pin synchroniser: a change counts once stages two and three agree.
    // ****************************************************************
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_s1 <= 16'h0000;
            pin_s2 <= 16'h0000;
            pin_s3 <= 16'h0000;
            pin_ok <= 16'h0000;
        end else begin
            pin_s1 <= PORT_PIN_I;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_ok <= (pin_s2 == pin_s3) ? pin_s3 : pin_ok;
        end
    end
    // ****************************************************************
    // Registered outputs towards the core.
    // ****************************************************************
    logic [15:0] n_dec_ptr, n_pop_sp, n_push_sp, n_port_rd;
    logic [2:0]  n_gnt;
    logic        n_ack, n_half, n_full;
    // Computes the pointer, stack, ack, grant, port read and stall results for the next edge.
    always_comb begin
        // Decode reads current values, so the write in execute is unseen.
        n_dec_ptr = arch[ptr_id(DEC_USE_I)];
        n_pop_sp  = arch[`ID_STACK_PTR];
        // Stack writes take the execute value straight away.
        n_push_sp = (wr_ok && EXE_WR_I.id == `ID_STACK_PTR) ?
                    EXE_WR_I.data : arch[`ID_STACK_PTR];
        // Prioritisation runs on the status word one instruction old.
        n_ack = adv && IRQ_I && lag[`ID_STATUS_WORD][`PSW_IEN_BIT] &&
                (IRQ_LVL_I > lag[`ID_STATUS_WORD][`PSW_LVL_LSB +: 4]);
        // Fixed bus priority: write, then fetch, then read.
        n_gnt = 3'b000;
        if (BUS_REQ_I[`REQ_WRITE]) begin
            n_gnt[`REQ_WRITE] = 1'b1;
        end else if (BUS_REQ_I[`REQ_FETCH]) begin
            n_gnt[`REQ_FETCH] = 1'b1;
        end else if (BUS_REQ_I[`REQ_READ]) begin
            n_gnt[`REQ_READ] = 1'b1;
        end
        // Whole-word port read: latch for outputs, pin level for inputs.
        n_port_rd = (lag[`ID_PORT_DIR] & arch[`ID_PORT_LATCH]) |
                    (~lag[`ID_PORT_DIR] & pin_ok);
        // Half cycle for reading a register just written, full for flags.
        n_half = DEC_USE_I.sfr_read && wr_ok &&
                 EXE_WR_I.id == DEC_USE_I.sfr_id;
        n_full = DEC_USE_I.tests_flags && (FLAG_WR_I ||
                 (wr_ok && EXE_WR_I.id == `ID_STATUS_WORD));
    end
    // Registers the core-facing results.
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            DEC_PTR_O      <= 16'h0000;
            POP_SP_O       <= 16'h0000;
            PUSH_SP_O      <= 16'h0000;
            IRQ_ACK_O      <= 1'b0;
            BUS_GNT_O      <= 3'b000;
            PORT_DIR_O     <= 16'h0000;
            PORT_RD_O      <= 16'h0000;
            SYS_CFG_O      <= 16'h0000;
            BUS_AREA_O     <= 32'h0000_0000;
            ROM_FETCH_EN_O <= 1'b0;
            STALL_HALF_O   <= 1'b0;
            STALL_FULL_O   <= 1'b0;
            RETIRE_O       <= 1'b0;
        end else begin
            DEC_PTR_O      <= n_dec_ptr;
            POP_SP_O       <= n_pop_sp;
            PUSH_SP_O      <= n_push_sp;
            IRQ_ACK_O      <= n_ack;
            BUS_GNT_O      <= n_gnt;
            PORT_DIR_O     <= lag[`ID_PORT_DIR];
            PORT_RD_O      <= n_port_rd;
            SYS_CFG_O      <= lag[`ID_SYS_CONFIG];
            BUS_AREA_O     <= {lag[`ID_ADDR_WINDOW],
                               lag[`ID_BUS_PROPS]};
            ROM_FETCH_EN_O <= rom_en;
            STALL_HALF_O   <= n_half;
            STALL_FULL_O   <= n_full;
            RETIRE_O       <= adv && stage[3];
        end
    end
    // ****************************************************************
    // AHB-Lite slave: zero wait states, always OKAY.
    // ****************************************************************
    logic        addr_ph;                  // Valid address phase.
    logic [31:0] rd_mux;                   // Read value by offset.
    assign addr_ph = HSEL && HREADY && HTRANS[1];
    // Selects the read value; unmapped offsets read zero.
    always_comb begin
        unique case (HADDR[7:0])
            `OFS_CTRL:        rd_mux = ctrl;
            `OFS_STATUS:      rd_mux = {haz_cnt, 12'h000, stage};
            `OFS_BANK_BASE:   rd_mux = {16'h0000, arch[`ID_BANK_BASE]};
            `OFS_STACK_PTR:   rd_mux = {16'h0000, arch[`ID_STACK_PTR]};
            `OFS_STATUS_WORD: rd_mux = {16'h0000, arch[`ID_STATUS_WORD]};
            `OFS_PORT_VIEW:   rd_mux = {lag[`ID_PORT_DIR], PORT_RD_O};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end
    // Captures the address phase and loads read data for the data phase.
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            bus_wr_q   <= 1'b0;
            bus_addr_q <= 8'h00;
            HRDATA     <= 32'h0000_0000;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
        end else begin
            bus_wr_q   <= addr_ph && HWRITE;
            bus_addr_q <= HADDR[7:0];
            HRDATA     <= (addr_ph && !HWRITE) ? rd_mux : 32'h0000_0000;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
        end
    end
    // ****************************************************************
    // Assertions and covers.
    // ****************************************************************
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    stage_shift_a: assert property (adv |=> stage[3:1] == $past(stage[2:0]))
        else $error("Pipeline stages did not shift on a step.");
    push_fwd_a: assert property (wr_ok && EXE_WR_I.id == `ID_STACK_PTR
        |=> PUSH_SP_O == $past(EXE_WR_I.data))
        else $error("Stack write did not get the forwarded pointer.");
    pop_stale_a: assert property (wr_ok && EXE_WR_I.id == `ID_STACK_PTR
        |=> POP_SP_O == $past(arch[`ID_STACK_PTR]))
        else $error("Pop saw a pointer written just before.");
    ack_enable_a: assert property (IRQ_ACK_O
        |-> $past(lag[`ID_STATUS_WORD][`PSW_IEN_BIT]) && $past(adv))
        else $error("Interrupt acknowledged without lagged enable.");
    bus_prio_a: assert property (BUS_REQ_I[`REQ_WRITE]
        |=> BUS_GNT_O == 3'b001)
        else $error("Data write did not win the bus.");
    dir_lag_a: assert property (adv ##1 adv
        |=> PORT_DIR_O == $past(arch[`ID_PORT_DIR], 2))
        else $error("Port direction did not lag by one instruction.");
    rom_branch_a: assert property ($changed(rom_en)
        |-> $past(adv && ABS_BRANCH_I))
        else $error("ROM fetch enable moved without a branch.");
    psw_exe_a: assert property (adv && wr_ok &&
        EXE_WR_I.id == `ID_STATUS_WORD
        |=> arch[`ID_STATUS_WORD] == $past(EXE_WR_I.data))
        else $error("Status word write not taken in execute.");
    stall_half_a: assert property (DEC_USE_I.sfr_read && wr_ok &&
        EXE_WR_I.id == DEC_USE_I.sfr_id |=> STALL_HALF_O)
        else $error("Half-cycle stall not raised.");
    pin_accept_a: assert property ($changed(pin_ok)
        |-> $past(pin_s2 == pin_s3))
        else $error("Pin level accepted before stages agreed.");
    full_pipe_c: cover property (stage == 4'hf);
    irq_ack_c: cover property (IRQ_ACK_O);
    hazard_c: cover property (haz_cnt != 16'h0000);
    rom_on_c: cover property (ROM_FETCH_EN_O);
endmodule // pipe_hazard_ctrl

// File: bench/cpu_pipeline_hazard_control_tb_top.sv
// Self-checking bench for the pipeline hazard controller.
`include "pipe_hazard_regs.svh"
module cpu_pipeline_hazard_control_tb_top;
    import pipe_hazard_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Signals towards the design.
    // ************************************************************
    logic CLK_I, RST_B_I, ADV_I, FETCH_VALID_I, ABS_BRANCH_I, FLAG_WR_I;
    logic IRQ_I, HSEL, HWRITE, HREADYOUT, HRESP, IRQ_ACK_O, RETIRE_O;
    logic STALL_HALF_O, STALL_FULL_O, ROM_FETCH_EN_O;
    exe_wr_s     EXE_WR_I;
    dec_use_s    DEC_USE_I;
    logic [3:0]  FLAG_VAL_I, IRQ_LVL_I;
    logic [2:0]  BUS_REQ_I, BUS_GNT_O;
    logic [1:0]  HTRANS;
    logic [15:0] PORT_PIN_I, DEC_PTR_O, POP_SP_O, PUSH_SP_O, PORT_DIR_O;
    logic [15:0] PORT_RD_O, SYS_CFG_O;
    logic [31:0] HADDR, HWDATA, HRDATA, BUS_AREA_O, rd;
    int          num_errors, checked, acks, return_inter_segment;
    pipe_hazard_ctrl u_pipe_hazard_ctrl (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
        .ADV_I(ADV_I), .FETCH_VALID_I(FETCH_VALID_I),
        .ABS_BRANCH_I(ABS_BRANCH_I), .EXE_WR_I(EXE_WR_I),
        .FLAG_WR_I(FLAG_WR_I), .FLAG_VAL_I(FLAG_VAL_I),
        .DEC_USE_I(DEC_USE_I), .IRQ_I(IRQ_I), .IRQ_LVL_I(IRQ_LVL_I),
        .BUS_REQ_I(BUS_REQ_I), .PORT_PIN_I(PORT_PIN_I),
        .DEC_PTR_O(DEC_PTR_O), .POP_SP_O(POP_SP_O), .PUSH_SP_O(PUSH_SP_O),
        .IRQ_ACK_O(IRQ_ACK_O), .BUS_GNT_O(BUS_GNT_O),
        .PORT_DIR_O(PORT_DIR_O), .PORT_RD_O(PORT_RD_O),
        .SYS_CFG_O(SYS_CFG_O), .BUS_AREA_O(BUS_AREA_O),
        .ROM_FETCH_EN_O(ROM_FETCH_EN_O), .STALL_HALF_O(STALL_HALF_O),
        .STALL_FULL_O(STALL_FULL_O), .RETIRE_O(RETIRE_O), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP));
    // ************************************************************
    // Clock, checks and closing.
    // ************************************************************
    // The 125 MHz clock.
    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end
    // Compares one result and counts it.
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Waits for hready under a bound; a hang counts as a mismatch.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (HREADYOUT !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask
    // One single AHB-Lite word transfer; read data taken at the last edge.
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge CLK_I);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HADDR  <= {24'h0, a};
        HWRITE <= w;
        wait_ready();
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        wait_ready();
        r = HRDATA;
        chk("response", 32'h0, {31'h0, HRESP});
    endtask
    // One pipeline step carrying an optional execute-stage write.
    task automatic step(input logic fv, br, v, input sfr_id_t id,
                        input logic [15:0] d);
        @(posedge CLK_I);
        ADV_I         <= 1'b1;
        FETCH_VALID_I <= fv;
        ABS_BRANCH_I  <= br;
        EXE_WR_I      <= '{v, id, d};
        @(posedge CLK_I);
        ADV_I         <= 1'b0;
        FETCH_VALID_I <= 1'b0;
        ABS_BRANCH_I  <= 1'b0;
        EXE_WR_I      <= '0;
        @(negedge CLK_I);
        acks += int'(IRQ_ACK_O === 1'b1);
        return_inter_segment += int'(RETIRE_O === 1'b1);
    endtask
    // One cycle without a step.
    task automatic idle();
        @(posedge CLK_I);
        @(negedge CLK_I);
    endtask
    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        {ADV_I, FETCH_VALID_I, ABS_BRANCH_I, FLAG_WR_I, IRQ_I} = '0;
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        {EXE_WR_I, DEC_USE_I, FLAG_VAL_I, IRQ_LVL_I, BUS_REQ_I} = '0;
        {num_errors, checked, acks, return_inter_segment} = '0;
        PORT_PIN_I = 16'ha5a5;
        RST_B_I = 1'b0;
        repeat (16) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        @(posedge CLK_I);
        ahb(1'b0, `OFS_CTRL, 32'h0, rd);
        chk("ctrl reset", `CTRL_RESET, rd);
        ahb(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        // Stack pointer write: pushes see it at once, pops one cycle late.
        step(1'b0, 1'b0, 1'b1, `ID_STACK_PTR, 16'hfa40);
        chk("push sp", 32'hfa40, {16'h0, PUSH_SP_O});
        chk("pop sp old", 32'h0, {16'h0, POP_SP_O});
        idle();
        chk("pop sp new", 32'hfa40, {16'h0, POP_SP_O});
        // Steps are ignored while the run bit is clear.
        ahb(1'b1, `OFS_CTRL, 32'h0, rd);
        step(1'b0, 1'b0, 1'b1, `ID_STACK_PTR, 16'h2222);
        ahb(1'b0, `OFS_STACK_PTR, 32'h0, rd);
        chk("sp held", 32'hfa40, rd);
        ahb(1'b1, `OFS_CTRL, 32'h1, rd);
        // Bus grant priority for every non-zero request pattern.
        for (int i = 1; i < 8; i++) begin
            @(posedge CLK_I);
            BUS_REQ_I <= i[2:0];
            idle();
            chk("grant", (i[0] ? 32'h1 : i[1] ? 32'h2 : 32'h4),
                {29'h0, BUS_GNT_O});
        end
        @(posedge CLK_I);
        BUS_REQ_I <= 3'h0;
        // Port latch then direction; the read view follows the lag.
        step(1'b0, 1'b0, 1'b1, `ID_PORT_LATCH, 16'h0ff0);
        step(1'b0, 1'b0, 1'b1, `ID_PORT_DIR, 16'h00ff);
        idle();
        chk("dir old", 32'h0, {16'h0, PORT_DIR_O});
        chk("read pins", 32'ha5a5, {16'h0, PORT_RD_O});
        step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        idle();
        chk("dir new", 32'h00ff, {16'h0, PORT_DIR_O});
        chk("read latch", 32'ha5f0, {16'h0, PORT_RD_O});
        // Interrupt enable and disable both lag by one instruction.
        @(posedge CLK_I);
        IRQ_I     <= 1'b1;
        IRQ_LVL_I <= 4'h1;
        acks = 0;
        step(1'b0, 1'b0, 1'b1, `ID_STATUS_WORD, 16'h0800);
        chk("no ack", 32'h0, {31'h0, IRQ_ACK_O});
        ahb(1'b0, `OFS_STATUS_WORD, 32'h0, rd);
        chk("status word", 32'h0800, rd);
        step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        chk("ack seen", 32'h1, {31'h0, acks != 0});
        step(1'b0, 1'b0, 1'b1, `ID_STATUS_WORD, 16'h0000);
        chk("late ack", 32'h1, {31'h0, IRQ_ACK_O});
        step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        chk("ack off", 32'h0, {31'h0, IRQ_ACK_O});
        @(posedge CLK_I);
        IRQ_I <= 1'b0;
        // System configuration and ROM fetch after an absolute branch.
        step(1'b0, 1'b0, 1'b1, `ID_SYS_CONFIG, 16'h0400);
        idle();
        chk("cfg old", 32'h0, {16'h0, SYS_CFG_O});
        step(1'b0, 1'b0, 1'b1, `ID_BUS_PROPS, 16'h1234);
        idle();
        chk("cfg new", 32'h0400, {16'h0, SYS_CFG_O});
        chk("rom off", 32'h0, {31'h0, ROM_FETCH_EN_O});
        chk("area old", 32'h0, BUS_AREA_O);
        step(1'b0, 1'b1, 1'b0, 4'h0, 16'h0);
        idle();
        chk("rom on", 32'h1, {31'h0, ROM_FETCH_EN_O});
        chk("area new", 32'h1234, BUS_AREA_O);
        // Flag test while flags are written, and SFR read after write.
        @(posedge CLK_I);
        DEC_USE_I <= '{1'b0, 1'b0, 2'h0, 1'b0, 1'b1, `ID_STATUS_WORD, 1'b1};
        FLAG_WR_I <= 1'b1;
        step(1'b0, 1'b0, 1'b1, `ID_STATUS_WORD, 16'h0001);
        chk("stall full", 32'h1, {31'h0, STALL_FULL_O});
        chk("stall half", 32'h1, {31'h0, STALL_HALF_O});
        @(posedge CLK_I);
        DEC_USE_I <= '0;
        FLAG_WR_I <= 1'b0;
        // One isolated instruction retires no sooner than its fourth step.
        return_inter_segment = 0;
        step(1'b1, 1'b0, 1'b0, 4'h0, 16'h0);
        repeat (2) step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        chk("early retire", 32'h0, return_inter_segment);
        repeat (3) step(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        chk("retire", 32'h1, return_inter_segment);
        // Stale page and bank pointers in decode, counted as hazards.
        @(posedge CLK_I);
        DEC_USE_I <= '{1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 4'h0, 1'b0};
        step(1'b0, 1'b0, 1'b1, `ID_PAGE0 + 4'h1, 16'h0055);
        chk("page stale", 32'h0, {16'h0, DEC_PTR_O});
        idle();
        chk("page new", 32'h0055, {16'h0, DEC_PTR_O});
        @(posedge CLK_I);
        DEC_USE_I <= '{1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 4'h0, 1'b0};
        step(1'b0, 1'b0, 1'b1, `ID_BANK_BASE, 16'h1100);
        chk("bank stale", 32'h0, {16'h0, DEC_PTR_O});
        idle();
        chk("bank new", 32'h1100, {16'h0, DEC_PTR_O});
        @(posedge CLK_I);
        DEC_USE_I <= '0;
        // Both stale uses are counted; a write of the clear bit empties it.
        ahb(1'b0, `OFS_STATUS, 32'h0, rd);
        chk("hazards", 32'h0002_0000, rd);
        ahb(1'b1, `OFS_CTRL, 32'h3, rd);
        ahb(1'b0, `OFS_STATUS, 32'h0, rd);
        chk("hazards clr", 32'h0, rd);
        ahb(1'b0, `OFS_CTRL, 32'h0, rd);
        chk("ctrl run", `CTRL_RESET, rd);
        ahb(1'b0, `OFS_BANK_BASE, 32'h0, rd);
        chk("bank reg", 32'h1100, rd);
        stop_test();
    end
endmodule // cpu_pipeline_hazard_control_tb_top
